/* File: core/tesf_chan.sv */
`default_nettype none
module tesf_chan #(
	parameter bit HAS_UD = 1'b0
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	tesf_chan_if.chan ch
);
	import tesf_pkg::*;

	typedef struct packed {
		logic [7:0] flags_q;
		logic       mode_q;
	} tesf_chan_st_t;

	tesf_chan_st_t st;
	tesf_chan_st_t nx;
	logic          mode;
	logic [7:0]    set;
	logic [7:0]    layout;

	always_comb begin
		mode = HAS_UD & ch.updown_count_enable;
		set = 8'h00;
		if (mode) begin
			set[BIT_UD_OVF] = ch.ud_overflow;
			set[BIT_UD_UNF] = ch.ud_underflow;
			set[BIT_UD_STEP] = ch.ud_step;
		end else begin
			set[BIT_CMP0] = ch.cmp0_match;
			set[BIT_CMP1] = ch.cmp1_match;
			set[BIT_OVF] = ch.up_overflow;
		end
		layout = mode ? LAYOUT_UPDOWN : LAYOUT_NORMAL;
		nx = st;
		nx.mode_q = mode;
		// Flags of the old layout mean nothing in the new one
		if (mode != st.mode_q) begin
			nx.flags_q = FLAGS_RST;
			set = 8'h00;
		end else begin
			// Set wins over a read clear in the same cycle
			nx.flags_q = ((st.flags_q & ~ch.rd_clr) | set) & layout;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st <= '{flags_q: FLAGS_RST, mode_q: 1'b0};
		end else begin
			st <= nx;
		end
	end

	assign ch.flags = st.flags_q;
	assign ch.set_vec = set;

	flag_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
		set != 8'h00 |=> (st.flags_q & $past(set)) == $past(set))
		else $error("event did not set its flag");
	flag_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(st.mode_q == mode) && ch.rd_clr == 8'h00 |=> ($past(st.flags_q) & ~st.flags_q) == 8'h00)
		else $error("flag dropped without a read");
	layout_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(st.flags_q & ~(st.mode_q ? LAYOUT_UPDOWN : LAYOUT_NORMAL)) == 8'h00)
		else $error("bit outside active layout is set");
	normal_only_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!HAS_UD |-> !st.mode_q && (st.flags_q & ~LAYOUT_NORMAL) == 8'h00)
		else $error("normal-only channel left normal layout");
	mode_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$changed(st.mode_q) |-> st.flags_q == FLAGS_RST)
		else $error("flags kept across layout change");
	step_flag_c: cover property (@(posedge clk_in) disable iff (rst_in)
		st.mode_q && st.flags_q[BIT_UD_STEP]);
endmodule
`default_nettype wire

/* File: core/tesf_chan_if.sv */
`default_nettype none
interface tesf_chan_if;
	logic       cmp0_match;
	logic       cmp1_match;
	logic       up_overflow;
	logic       ud_step;
	logic       ud_underflow;
	logic       ud_overflow;
	logic       updown_count_enable;
	logic [7:0] rd_clr;
	logic [7:0] flags;
	logic [7:0] set_vec;
	modport chan (
		input  cmp0_match, cmp1_match, up_overflow, ud_step, ud_underflow, ud_overflow,
		input  updown_count_enable, rd_clr,
		output flags, set_vec
	);
	modport ctrl (
		output cmp0_match, cmp1_match, up_overflow, ud_step, ud_underflow, ud_overflow,
		output updown_count_enable, rd_clr,
		input  flags, set_vec
	);
endinterface
`default_nettype wire

/* File: core/tesf_pkg.sv */
// Functional notes
// - Normal mode: bit 0 sets on counter match with first compare register.
// - Normal mode: bit 1 sets on counter match with second compare register.
// - Normal mode: bit 2 sets on up-counter overflow.
// - Up-down count enable bit selects normal (0) or two-phase counter (1) layout.
// - Two-phase mode: bit 4 sets on any increment or decrement.
// - Two-phase mode: bit 3 sets on up-down counter underflow.
// - Two-phase mode: bit 2 sets on up-down counter overflow.
// - Each flag reads 0 until its event is seen, then 1.
// - Channels 4 and 5 only have the normal layout.
`default_nettype none
package tesf_pkg;
	localparam int          NUM_CH                     = 4;
	localparam int          NUM_UD                     = 2;
	// Status registers of channels 2..5, byte addresses
	localparam logic [31:0] ADDR_STAT [NUM_CH]         = '{32'hFFFFF164, 32'hFFFFF174,
	                                                       32'hFFFFF184, 32'hFFFFF194};
	localparam logic [31:0] ADDR_MODE                  = 32'hFFFFF1F0;
	localparam logic [31:0] ADDR_IRQ_PEND              = 32'hFFFFF1F4;
	localparam logic [31:0] ADDR_IRQ_MASK              = 32'hFFFFF1F8;
	localparam int          CH2_UPDOWN_COUNT_ENABLE_BIT = 0;
	localparam int          CH3_UPDOWN_COUNT_ENABLE_BIT = 1;
	localparam int          BIT_CMP0                   = 0;
	localparam int          BIT_CMP1                   = 1;
	localparam int          BIT_OVF                    = 2;
	localparam int          BIT_UD_OVF                 = 2;
	localparam int          BIT_UD_UNF                 = 3;
	localparam int          BIT_UD_STEP                = 4;
	localparam logic [7:0]  LAYOUT_NORMAL              = 8'h07;
	localparam logic [7:0]  LAYOUT_UPDOWN              = 8'h1C;
	localparam logic [7:0]  FLAGS_RST                  = 8'h00;
	localparam logic [1:0]  MODE_RST                   = 2'h0;
	localparam logic [31:0] PEND_RST                   = 32'h00000000;
	localparam logic [31:0] MASK_RST                   = 32'h00000000;
	localparam logic [31:0] RDATA_RST                  = 32'h00000000;
endpackage
`default_nettype wire

/* File: core/tesf_top.sv */
`default_nettype none
module tesf_top (
	input  wire logic                        clk_in,
	input  wire logic                        rst_in,
	input  wire logic                        psel_in,
	input  wire logic                        penable_in,
	input  wire logic                        pwrite_in,
	input  wire logic [31:0]                 paddr_in,
	input  wire logic [31:0]                 pwdata_in,
	output logic      [31:0]                 prdata_out,
	output logic                             pready_out,
	output logic                             pslverr_out,
	output logic                             irq_out,
	input  wire logic [tesf_pkg::NUM_CH-1:0] cmp0_match_in,
	input  wire logic [tesf_pkg::NUM_CH-1:0] cmp1_match_in,
	input  wire logic [tesf_pkg::NUM_CH-1:0] up_overflow_in,
	input  wire logic [tesf_pkg::NUM_UD-1:0] ud_step_in,
	input  wire logic [tesf_pkg::NUM_UD-1:0] ud_underflow_in,
	input  wire logic [tesf_pkg::NUM_UD-1:0] ud_overflow_in
);
	import tesf_pkg::*;

	typedef struct packed {
		logic [31:0] prdata_q;
		logic        err_q;
		logic [1:0]  mode_q;
		logic [31:0] pend_q;
		logic [31:0] mask_q;
	} tesf_top_st_t;

	tesf_top_st_t              st;
	tesf_top_st_t              nx;
	logic [NUM_CH-1:0]         st_hit;
	logic                      hit_mode;
	logic                      hit_pend;
	logic                      hit_mask;
	logic                      hit_any;
	logic                      setup;
	logic                      access;
	logic [31:0]               rd_word;
	logic [NUM_CH-1:0][7:0]    flags_w;
	logic [NUM_CH-1:0][7:0]    set_w;
	logic [31:0]               set_all;

	tesf_chan_if ch_if [NUM_CH] ();

	////////////////////////////////////////////////////////////////////////
	// Channels

	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		assign ch_if[g].cmp0_match = cmp0_match_in[g];
		assign ch_if[g].cmp1_match = cmp1_match_in[g];
		assign ch_if[g].up_overflow = up_overflow_in[g];
		// Only a completed read clears, and only the bits it returned
		assign ch_if[g].rd_clr = (access && !pwrite_in && st_hit[g]) ? st.prdata_q[7:0] : 8'h00;
		assign flags_w[g] = ch_if[g].flags;
		assign set_w[g] = ch_if[g].set_vec;
		if (g < NUM_UD) begin : g_ud
			assign ch_if[g].ud_step = ud_step_in[g];
			assign ch_if[g].ud_underflow = ud_underflow_in[g];
			assign ch_if[g].ud_overflow = ud_overflow_in[g];
			assign ch_if[g].updown_count_enable = st.mode_q[g];
		end else begin : g_norm
			assign ch_if[g].ud_step = 1'b0;
			assign ch_if[g].ud_underflow = 1'b0;
			assign ch_if[g].ud_overflow = 1'b0;
			assign ch_if[g].updown_count_enable = 1'b0;
		end
		tesf_chan #(
			.HAS_UD (g < NUM_UD)
		) u_chan (
			.clk_in (clk_in),
			.rst_in (rst_in),
			.ch     (ch_if[g])
		);
	end

	assign set_all = set_w;

	////////////////////////////////////////////////////////////////////////
	// APB decode

	always_comb begin
		setup = psel_in && !penable_in;
		access = psel_in && penable_in;
		for (int i = 0; i < NUM_CH; i++) begin
			st_hit[i] = (paddr_in == ADDR_STAT[i]);
		end
		hit_mode = (paddr_in == ADDR_MODE);
		hit_pend = (paddr_in == ADDR_IRQ_PEND);
		hit_mask = (paddr_in == ADDR_IRQ_MASK);
		hit_any = (|st_hit) || hit_mode || hit_pend || hit_mask;
		rd_word = 32'h00000000;
		for (int i = 0; i < NUM_CH; i++) begin
			if (st_hit[i]) begin
				rd_word = {24'h000000, flags_w[i]};
			end
		end
		if (hit_mode) begin
			rd_word = {30'h0, st.mode_q};
		end
		if (hit_pend) begin
			rd_word = st.pend_q;
		end
		if (hit_mask) begin
			rd_word = st.mask_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_comb begin
		nx = st;
		// Read data and error are latched in the setup cycle so both come from flops
		if (setup) begin
			nx.prdata_q = pwrite_in ? RDATA_RST : rd_word;
			nx.err_q = !hit_any;
		end
		nx.pend_q = st.pend_q | set_all;
		if (access && pwrite_in) begin
			if (hit_mode) begin
				nx.mode_q = pwdata_in[1:0];
			end
			if (hit_mask) begin
				nx.mask_q = pwdata_in;
			end
			if (hit_pend) begin
				// New events win over the clear
				nx.pend_q = (st.pend_q & ~pwdata_in) | set_all;
			end
			// Status register writes fall through untouched
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st <= '{prdata_q: RDATA_RST, err_q: 1'b0, mode_q: MODE_RST,
			        pend_q: PEND_RST, mask_q: MASK_RST};
		end else begin
			st <= nx;
		end
	end

	assign prdata_out = st.prdata_q;
	assign pready_out = 1'b1;
	assign pslverr_out = access && st.err_q;
	assign irq_out = |(st.pend_q & st.mask_q);

	////////////////////////////////////////////////////////////////////////
	// Checks

	ch2_cmp0_a: assert property (@(posedge clk_in) disable iff (rst_in)
		cmp0_match_in[0] && !st.mode_q[0] && $stable(st.mode_q) |=> flags_w[0][BIT_CMP0])
		else $error("ch2 compare 0 match not flagged");
	ch5_cmp1_a: assert property (@(posedge clk_in) disable iff (rst_in)
		cmp1_match_in[3] |=> flags_w[3][BIT_CMP1])
		else $error("ch5 compare 1 match not flagged");
	ch4_ovf_a: assert property (@(posedge clk_in) disable iff (rst_in)
		up_overflow_in[2] |=> flags_w[2][BIT_OVF])
		else $error("ch4 overflow not flagged");
	ch3_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ud_step_in[1] && st.mode_q[1] && $stable(st.mode_q) |=> flags_w[1][BIT_UD_STEP])
		else $error("ch3 step not flagged");
	ch2_unf_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ud_underflow_in[0] && st.mode_q[0] && $stable(st.mode_q) |=> flags_w[0][BIT_UD_UNF])
		else $error("ch2 underflow not flagged");
	ch3_udovf_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ud_overflow_in[1] && st.mode_q[1] && $stable(st.mode_q) |=> flags_w[1][BIT_UD_OVF])
		else $error("ch3 up-down overflow not flagged");
	normal_ignore_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!st.mode_q[0] && !$past(st.mode_q[0]) |-> !flags_w[0][BIT_UD_UNF] && !flags_w[0][BIT_UD_STEP])
		else $error("ch2 up-down flag in normal layout");
	write_ignored_a: assert property (@(posedge clk_in) disable iff (rst_in)
		access && pwrite_in && (|st_hit) && set_all == 32'h00000000
		|=> flags_w == $past(flags_w))
		else $error("status write changed flags");
	read_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
		access && !pwrite_in && st_hit[2] && set_w[2] == 8'h00 && st.prdata_q[BIT_CMP0]
		|=> !flags_w[2][BIT_CMP0])
		else $error("read did not clear returned flag");
	read_data_a: assert property (@(posedge clk_in) disable iff (rst_in)
		setup && !pwrite_in && st_hit[3] |=> prdata_out == {24'h000000, $past(flags_w[3])})
		else $error("status read returned wrong data");
	unmapped_a: assert property (@(posedge clk_in) disable iff (rst_in)
		setup && !hit_any |=> pslverr_out || !access)
		else $error("unmapped access without error");
	pend_w1c_a: assert property (@(posedge clk_in) disable iff (rst_in)
		access && pwrite_in && hit_pend && pwdata_in[0] && !set_all[0] |=> !st.pend_q[0])
		else $error("pending bit not cleared by write one");
	irq_level_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(set_all & st.mask_q) != 32'h00000000 && !(access && pwrite_in && hit_mask) |=> irq_out)
		else $error("masked-in event did not raise interrupt");

	ud_mode_c: cover property (@(posedge clk_in) disable iff (rst_in)
		st.mode_q[0] && flags_w[0][BIT_UD_OVF]);
	irq_rise_c: cover property (@(posedge clk_in) disable iff (rst_in) $rose(irq_out));
	read_clear_c: cover property (@(posedge clk_in) disable iff (rst_in)
		access && !pwrite_in && st.prdata_q != 32'h00000000);
	unmapped_c: cover property (@(posedge clk_in) disable iff (rst_in) pslverr_out);
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import tesf_pkg::*;

	logic              clk_in, rst_in, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [31:0]       paddr, pwdata, prdata, rd;
	logic [NUM_CH-1:0] cmp0, cmp1, upovf;
	logic [NUM_UD-1:0] udstep, udunf, udovf;
	logic [7:0]        exp_ud [6] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h08, 8'h04};
	int                n_mismatch, n_checks;

	tesf_top dut (
		.clk_in          (clk_in),
		.rst_in          (rst_in),
		.psel_in         (psel),
		.penable_in      (penable),
		.pwrite_in       (pwrite),
		.paddr_in        (paddr),
		.pwdata_in       (pwdata),
		.prdata_out      (prdata),
		.pready_out      (pready),
		.pslverr_out     (pslverr),
		.irq_out         (irq),
		.cmp0_match_in   (cmp0),
		.cmp1_match_in   (cmp1),
		.up_overflow_in  (upovf),
		.ud_step_in      (udstep),
		.ud_underflow_in (udunf),
		.ud_overflow_in  (udovf)
	);

	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
			n_mismatch++;
		end
	endtask

	// Holds the request until pready is seen high, then releases
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_in);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk_in);
		penable <= 1'b1;
		@(posedge clk_in);
		while (pready !== 1'b1) begin
			n++;
			if (n > 50) begin
				n_mismatch++;
				conclude();
			end
			@(posedge clk_in);
		end
		// Answer taken at the very edge that samples pready high
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// One-cycle event pulse: kinds 0..5 are cmp0, cmp1, up ovf, step, underflow, ud ovf
	task automatic pulse(input int k, input int i);
		@(posedge clk_in);
		case (k)
			0: cmp0[i] <= 1'b1;
			1: cmp1[i] <= 1'b1;
			2: upovf[i] <= 1'b1;
			3: udstep[i] <= 1'b1;
			4: udunf[i] <= 1'b1;
			default: udovf[i] <= 1'b1;
		endcase
		@(posedge clk_in);
		{cmp0, cmp1, upovf, udstep, udunf, udovf} <= '0;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{cmp0, cmp1, upovf, udstep, udunf, udovf} = '0;
		rst_in = 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int c = 0; c < NUM_CH; c++) begin
			apb(1'b0, ADDR_STAT[c], 32'h0);
			chk("status after reset", rd, 32'h0);
		end
		apb(1'b0, ADDR_MODE, 32'h0);
		chk("mode after reset", rd, 32'h0);
		apb(1'b0, ADDR_IRQ_MASK, 32'h0);
		chk("mask after reset", rd, 32'h0);
		apb(1'b0, 32'hFFFFF168, 32'h0);
		chk("unmapped error", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		// Normal layout on every channel, each event alone
		for (int c = 0; c < NUM_CH; c++) begin
			for (int k = 0; k < 3; k++) begin
				pulse(k, c);
				apb(1'b0, ADDR_STAT[c], 32'h0);
				chk("normal flag", rd, 32'h1 << k);
				apb(1'b0, ADDR_STAT[c], 32'h0);
				chk("flag after read", rd, 32'h0);
			end
		end
		// Up-down events must not show in the normal layout
		for (int c = 0; c < NUM_UD; c++) begin
			for (int k = 3; k < 6; k++) begin
				pulse(k, c);
				apb(1'b0, ADDR_STAT[c], 32'h0);
				chk("inactive layout event", rd, 32'h0);
			end
		end
		pulse(0, 0);
		apb(1'b1, ADDR_STAT[0], 32'hFFFFFFFF);
		chk("status write error", {31'h0, err}, 32'h0);
		apb(1'b0, ADDR_STAT[0], 32'h0);
		chk("status after write", rd, 32'h1);
		// Two-phase layout on channels 2 and 3
		apb(1'b1, ADDR_MODE, 32'h3);
		apb(1'b0, ADDR_MODE, 32'h0);
		chk("mode readback", rd, 32'h3);
		for (int c = 0; c < NUM_UD; c++) begin
			for (int k = 0; k < 6; k++) begin
				pulse(k, c);
				apb(1'b0, ADDR_STAT[c], 32'h0);
				chk("updown flag", rd, {24'h0, exp_ud[k]});
			end
		end
		for (int c = 2; c < NUM_CH; c++) begin
			for (int k = 0; k < 3; k++) begin
				pulse(k, c);
				apb(1'b0, ADDR_STAT[c], 32'h0);
				chk("fixed layout flag", rd, 32'h1 << k);
			end
		end
		// Switching layout drops the flags gathered under the old one
		pulse(3, 0);
		apb(1'b1, ADDR_MODE, 32'h0);
		apb(1'b0, ADDR_STAT[0], 32'h0);
		chk("flags after layout change", rd, 32'h0);
		// Interrupt: raise, masked, unmask, clear
		apb(1'b1, ADDR_IRQ_PEND, 32'hFFFFFFFF);
		apb(1'b0, ADDR_IRQ_PEND, 32'h0);
		chk("pending cleared", rd, 32'h0);
		pulse(1, 2);
		apb(1'b0, ADDR_IRQ_PEND, 32'h0);
		chk("pending set", rd, 32'h00020000);
		chk("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, ADDR_IRQ_MASK, 32'h00020000);
		// A write lands at the access edge; look one edge later
		@(posedge clk_in);
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		apb(1'b1, ADDR_IRQ_PEND, 32'h00020000);
		@(posedge clk_in);
		chk("irq after clear", {31'h0, irq}, 32'h0);
		apb(1'b0, ADDR_IRQ_PEND, 32'h0);
		chk("pending after clear", rd, 32'h0);
		// Event while unmasked raises the line directly
		pulse(1, 2);
		@(posedge clk_in);
		chk("irq on unmasked event", {31'h0, irq}, 32'h1);
		// Mid-run reset with a flag, a mask bit and a pending bit set
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		apb(1'b0, ADDR_STAT[2], 32'h0);
		chk("status after mid reset", rd, 32'h0);
		apb(1'b0, ADDR_IRQ_MASK, 32'h0);
		chk("mask after mid reset", rd, 32'h0);
		chk("irq after mid reset", {31'h0, irq}, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
